// ==== hw/apmfc_top.sv ====
module apmfc_top
	import apmfc_pkg::*;
#(
	parameter int DEEP_WAKE_CYCLES = apmfc_pkg::DEEP_WAKE_CYCLES,
	parameter int FIFO_DEPTH       = apmfc_pkg::FIFO_DEPTH
) (
	input  wire logic                       mclk,
	input  wire logic                       sys_rst,
	input  wire logic                       clk_en,
	input  wire logic                       cs_n_pin,
	input  wire logic                       sclk_pin,
	input  wire logic                       sample_valid,
	input  wire logic [apmfc_pkg::RES_W-1:0] sample_a,
	input  wire logic [apmfc_pkg::RES_W-1:0] sample_b,
	output logic                            sample_ready,
	output logic                            conv_out_a,
	output logic                            conv_out_a_oe,
	output logic                            conv_out_b,
	output logic                            conv_out_b_oe,
	output apmfc_pkg::apmfc_mode_type       power_mode,
	output logic                            analog_pwr,
	output logic                            ref_pwr,
	output logic                            analog_ready,
	output logic                            track_mode
);
	import apmfc_pkg::*;

	localparam logic [WAKE_W-1:0] PART_LOAD = WAKE_W'(PARTIAL_WAKE_CYCLES);
	localparam logic [WAKE_W-1:0] DEEP_LOAD = WAKE_W'(DEEP_WAKE_CYCLES);

	// pin sampling and edges
	logic cs_n_s, sclk_s;
	logic cs_prev_q, cs_prev_d, sclk_prev_q, sclk_prev_d;
	logic cs_fall, cs_rise, sclk_fall, sclk_rise;

	apmfc_sync #(.RST_VAL(1'b1)) u_sync_cs (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.din     (cs_n_pin),
		.dout    (cs_n_s)
	);

	apmfc_sync #(.RST_VAL(1'b0)) u_sync_sclk (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.din     (sclk_pin),
		.dout    (sclk_s)
	);

	always_comb begin
		cs_prev_d   = cs_n_s;
		sclk_prev_d = sclk_s;
		cs_fall     = cs_prev_q && !cs_n_s;
		cs_rise     = !cs_prev_q && cs_n_s;
		sclk_fall   = sclk_prev_q && !sclk_s;
		sclk_rise   = !sclk_prev_q && sclk_s;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cs_prev_q   <= 1'b1;
			sclk_prev_q <= 1'b0;
		end else if (clk_en) begin
			cs_prev_q   <= cs_prev_d;
			sclk_prev_q <= sclk_prev_d;
		end
	end

	// result buffer: a frame that finds it empty shifts zeros
	logic              fifo_valid, fifo_pop;
	logic [WORD_W-1:0] fifo_data;

	apmfc_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.wr_valid (sample_valid),
		.wr_ready (sample_ready),
		.wr_data  ({sample_a, sample_b}),
		.rd_valid (fifo_valid),
		.rd_ready (fifo_pop),
		.rd_data  (fifo_data)
	);

	// frame shifter
	logic [FCNT_W-1:0] cnt_q, cnt_d, cnt_inc;
	logic              active_q, active_d;
	logic [RES_W-1:0]  res_a_q, res_a_d, res_b_q, res_b_d;
	logic              out_a_d, out_b_d, oe_d;

	function automatic logic bit_at(input logic [FCNT_W-1:0] n,
			input logic [RES_W-1:0] own, input logic [RES_W-1:0] other);
		logic b;
		b = 1'b0;
		if (n >= OWN_FIRST && n <= OWN_LAST) begin
			b = own[4'(OWN_LAST - n)];
		end else if (n >= OTHER_FIRST && n <= OTHER_LAST) begin
			b = other[4'(OTHER_LAST - n)];
		end
		return b;
	endfunction : bit_at

	always_comb begin
		cnt_inc  = cnt_q + 6'h01;
		cnt_d    = cnt_q;
		active_d = active_q;
		res_a_d  = res_a_q;
		res_b_d  = res_b_q;
		out_a_d  = conv_out_a;
		out_b_d  = conv_out_b;
		oe_d     = conv_out_a_oe;
		fifo_pop = 1'b0;
		if (cs_rise) begin
			active_d = 1'b0;
			oe_d     = 1'b0;
			out_a_d  = 1'b0;
			out_b_d  = 1'b0;
		end else if (cs_fall) begin
			active_d = 1'b1;
			cnt_d    = '0;
			oe_d     = 1'b1;
			out_a_d  = 1'b0;
			out_b_d  = 1'b0;
			fifo_pop = fifo_valid;
			res_a_d  = fifo_valid ? fifo_data[WORD_W-1:RES_W] : '0;
			res_b_d  = fifo_valid ? fifo_data[RES_W-1:0] : '0;
		end else if (sclk_fall && !cs_prev_q) begin
			if (cnt_q != FALLS_FRAME) begin
				cnt_d = cnt_inc;
			end
			if (active_q) begin
				// zeros fall out of bit_at at 0,1,14..17,30,31
				out_a_d = bit_at(cnt_inc, res_a_q, res_b_q);
				out_b_d = bit_at(cnt_inc, res_b_q, res_a_q);
				if (cnt_inc == FALLS_FRAME) begin
					active_d = 1'b0;
					oe_d     = 1'b0;
					out_a_d  = 1'b0;
					out_b_d  = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cnt_q         <= '0;
			active_q      <= 1'b0;
			res_a_q       <= '0;
			res_b_q       <= '0;
			conv_out_a    <= 1'b0;
			conv_out_b    <= 1'b0;
			conv_out_a_oe <= 1'b0;
			conv_out_b_oe <= 1'b0;
		end else if (clk_en) begin
			cnt_q         <= cnt_d;
			active_q      <= active_d;
			res_a_q       <= res_a_d;
			res_b_q       <= res_b_d;
			conv_out_a    <= out_a_d;
			conv_out_b    <= out_b_d;
			conv_out_a_oe <= oe_d;
			conv_out_b_oe <= oe_d;
		end
	end

	// power mode and wake timing
	apmfc_mode_type    mode_d;
	logic              analog_d, ref_d, ready_d, track_d;
	logic              waking_q, waking_d;
	logic [WAKE_W-1:0] wake_q, wake_d;

	always_comb begin
		mode_d   = power_mode;
		analog_d = analog_pwr;
		ref_d    = ref_pwr;
		ready_d  = analog_ready;
		track_d  = track_mode;
		waking_d = waking_q;
		wake_d   = wake_q;
		if (wake_q != '0) begin
			wake_d = wake_q - 1'b1;
			if (wake_q == 21'h000001) begin
				ready_d = 1'b1;
			end
		end
		if (cs_fall) begin
			track_d = 1'b0;
			if (power_mode != APMFC_NORMAL) begin
				analog_d = 1'b1;
				ref_d    = 1'b1;
				ready_d  = 1'b0;
				wake_d   = (power_mode == APMFC_PARTIAL) ? PART_LOAD : DEEP_LOAD;
				waking_d = power_mode == APMFC_PARTIAL;
			end
		end else if (cs_rise) begin
			waking_d = 1'b0;
			if (cnt_q < FALLS_PD_MIN) begin
				if (power_mode != APMFC_NORMAL) begin
					// wake started at the fall is dropped; mode unchanged
					analog_d = 1'b0;
					ref_d    = power_mode == APMFC_PARTIAL;
					ready_d  = 1'b0;
					wake_d   = '0;
					track_d  = 1'b0;
				end else begin
					track_d = 1'b1;
				end
			end else if (cnt_q < FALLS_AWAKE) begin
				mode_d   = (power_mode == APMFC_NORMAL) ? APMFC_PARTIAL : APMFC_FULL;
				analog_d = 1'b0;
				ref_d    = power_mode == APMFC_NORMAL;
				ready_d  = 1'b0;
				wake_d   = '0;
				track_d  = 1'b0;
			end else begin
				// wake counter keeps running if a power-up is still under way
				mode_d  = APMFC_NORMAL;
				track_d = 1'b1;
			end
		end else if (!cs_prev_q && !track_mode) begin
			if (waking_q && (sclk_fall || sclk_rise)) begin
				track_d = 1'b1;
			end else if (sclk_rise && cnt_q >= FALLS_TRACK) begin
				track_d = 1'b1;
			end
		end
	end

	// supply-on mode is undetermined; full power-down is the safe assumption
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			power_mode   <= APMFC_FULL;
			analog_pwr   <= 1'b0;
			ref_pwr      <= 1'b0;
			analog_ready <= 1'b0;
			track_mode   <= 1'b0;
			waking_q     <= 1'b0;
			wake_q       <= '0;
		end else if (clk_en) begin
			power_mode   <= mode_d;
			analog_pwr   <= analog_d;
			ref_pwr      <= ref_d;
			analog_ready <= ready_d;
			track_mode   <= track_d;
			waking_q     <= waking_d;
			wake_q       <= wake_d;
		end
	end

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst || !clk_en);

	a_oe_on_fall: assert property (cs_fall |=> conv_out_a_oe && conv_out_b_oe && !conv_out_a)
		else $error("data lines not enabled with leading zero after select fall");
	a_release_rise: assert property (cs_rise |=> !conv_out_a_oe && !conv_out_b_oe)
		else $error("data lines still driven after select rise");
	a_stop_frame: assert property (sclk_fall && !cs_prev_q && !cs_rise && active_q
			&& cnt_q == 6'h1F |=> !conv_out_a_oe)
		else $error("data line not released on fall thirty-two");
	a_trail_zero: assert property (sclk_fall && !cs_prev_q && !cs_rise && !cs_fall && active_q
			&& (cnt_q == 6'h0D || cnt_q == 6'h0E) |=> !conv_out_a && !conv_out_b)
		else $error("trailing zero missing");
	a_cross_data: assert property (sclk_fall && !cs_prev_q && !cs_rise && !cs_fall && active_q
			&& cnt_q == 6'h11 |=> conv_out_a == res_b_q[11] && conv_out_b == res_a_q[11])
		else $error("second result not from the other converter");
	a_enter_partial: assert property (cs_rise && power_mode == APMFC_NORMAL && cnt_q >= 6'h02
			&& cnt_q < 6'h0A |=> power_mode == APMFC_PARTIAL && !analog_pwr && ref_pwr)
		else $error("partial power-down not entered");
	a_glitch_keep: assert property (cs_rise && power_mode == APMFC_NORMAL && cnt_q < 6'h02
			|=> power_mode == APMFC_NORMAL)
		else $error("select glitch changed the mode");
	a_enter_full: assert property (cs_rise && power_mode == APMFC_PARTIAL && cnt_q >= 6'h02
			&& cnt_q < 6'h0A |=> power_mode == APMFC_FULL && !ref_pwr)
		else $error("full power-down not entered");
	a_wake_cancel: assert property (cs_rise && power_mode == APMFC_PARTIAL && cnt_q < 6'h02
			|=> power_mode == APMFC_PARTIAL && !analog_pwr)
		else $error("short frame did not cancel the wake");
	a_stay_awake: assert property (cs_rise && cnt_q >= 6'h0A |=> power_mode == APMFC_NORMAL
			&& analog_pwr)
		else $error("device not powered after long frame");
	a_partial_wake: assert property (cs_fall && power_mode == APMFC_PARTIAL
			|-> ##[1:60] (analog_ready || !analog_pwr))
		else $error("partial wake took too long");
	a_track_first: assert property (waking_q && !track_mode && !cs_prev_q && !cs_rise && !cs_fall
			&& (sclk_fall || sclk_rise) |=> track_mode)
		else $error("sampler did not resume tracking on first clock edge");

	c_full_frame: cover property (sclk_fall && active_q && cnt_q == 6'h1F);
	c_partial: cover property (cs_rise && power_mode == APMFC_NORMAL && cnt_q == 6'h05);
	c_full: cover property (cs_rise && power_mode == APMFC_PARTIAL && cnt_q == 6'h05);
	c_wake: cover property (power_mode == APMFC_NORMAL && $rose(analog_ready));
endmodule : apmfc_top

// ==== hw/apmfc_pkg.sv ====
package apmfc_pkg;
	// clock and timing
	localparam int CLK_PERIOD_PS       = 4000;
	localparam int PARTIAL_WAKE_NS     = 200;
	localparam int PARTIAL_WAKE_CYCLES = (PARTIAL_WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DEEP_WAKE_MS        = 6;
	localparam longint DEEP_WAKE_PS    = longint'(DEEP_WAKE_MS) * 1000000000;
	localparam int DEEP_WAKE_CYCLES    = int'((DEEP_WAKE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int WAKE_W              = 21;

	// frame layout, counted in serial clock falling edges since the select fall
	localparam int FCNT_W                  = 6;
	localparam logic [FCNT_W-1:0] FALLS_PD_MIN = 6'h02;
	localparam logic [FCNT_W-1:0] FALLS_AWAKE  = 6'h0A;
	localparam logic [FCNT_W-1:0] FALLS_TRACK  = 6'h0D;
	localparam logic [FCNT_W-1:0] OWN_FIRST    = 6'h02;
	localparam logic [FCNT_W-1:0] OWN_LAST     = 6'h0D;
	localparam logic [FCNT_W-1:0] OTHER_FIRST  = 6'h12;
	localparam logic [FCNT_W-1:0] OTHER_LAST   = 6'h1D;
	localparam logic [FCNT_W-1:0] FALLS_FRAME  = 6'h20;

	// result word and buffer
	localparam int RES_W      = 12;
	localparam int WORD_W     = 2 * RES_W;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [1:0] {
		APMFC_NORMAL,
		APMFC_PARTIAL,
		APMFC_FULL
	} apmfc_mode_type;
endpackage : apmfc_pkg

// ==== hw/apmfc_sync.sv ====
module apmfc_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	input  wire logic din,
	output logic      dout
);
	logic meta_q;
	logic meta_d;
	logic dout_d;

	always_comb begin
		meta_d = din;
		dout_d = meta_q;
	end

	// first stage feeds only the second stage
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta_q <= RST_VAL;
			dout   <= RST_VAL;
		end else if (clk_en) begin
			meta_q <= meta_d;
			dout   <= dout_d;
		end
	end
endmodule : apmfc_sync

// ==== hw/apmfc_fifo.sv ====
module apmfc_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic                  rd_valid,
	input  wire logic             rd_ready,
	output logic      [WIDTH-1:0] rd_data
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wp_q, wp_d, rp_q, rp_d;
	logic [PW:0]      cnt_q, cnt_d;
	logic             wr_ready_d, rd_valid_d;
	logic             do_wr, do_rd;

	always_comb begin
		do_wr      = wr_valid && wr_ready;
		do_rd      = rd_valid && rd_ready;
		wp_d       = do_wr ? PW'((wp_q + 1'b1) % DEPTH) : wp_q;
		rp_d       = do_rd ? PW'((rp_q + 1'b1) % DEPTH) : rp_q;
		cnt_d      = cnt_q + (PW+1)'(do_wr) - (PW+1)'(do_rd);
		wr_ready_d = cnt_d != FULL_CNT;
		rd_valid_d = cnt_d != '0;
		rd_data    = mem_q[rp_q];
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wp_q     <= '0;
			rp_q     <= '0;
			cnt_q    <= '0;
			wr_ready <= 1'b1;
			rd_valid <= 1'b0;
		end else if (clk_en) begin
			wp_q     <= wp_d;
			rp_q     <= rp_d;
			cnt_q    <= cnt_d;
			wr_ready <= wr_ready_d;
			rd_valid <= rd_valid_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (clk_en && do_wr) begin
			mem_q[wp_q] <= wr_data;
		end
	end
endmodule : apmfc_fifo

// ==== testbench/apmfc_host.sv ====
module apmfc_host #(
	parameter int IDLE_GAP = 25
) (
	input  wire logic       mclk,
	output logic            cs_n_pin,
	output logic            sclk_pin,
	input  wire logic [5:0] probe
);
	timeunit 1ns;
	timeprecision 100ps;

	// probe bits: track, oe_b, out_b, oe_a, out_a, ready; one snapshot per fall count
	logic [5:0] cap [0:32];

	initial begin
		cs_n_pin = 1'b1;
		sclk_pin = 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wt

	// sclk idles high and stands still between frames; data is read just before each rise
	task automatic frame(input int falls, input int hp);
		cs_n_pin = 1'b0;
		wt(hp);
		cap[0] = probe;
		for (int k = 1; k <= falls; k++) begin
			sclk_pin = 1'b0;
			wt(hp);
			cap[k] = probe;
			sclk_pin = 1'b1;
			wt(hp);
		end
		// remaining clocks are not owed after an early rise
		cs_n_pin = 1'b1;
		wt(IDLE_GAP);
	endtask : frame
endmodule : apmfc_host

// ==== testbench/apmfc_top_tb_top.sv ====
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module apmfc_top_tb_top import apmfc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int DW = 200;

	logic             mclk;
	logic             sys_rst;
	logic             cs_n_pin;
	logic             sclk_pin;
	logic             sample_valid;
	logic             sample_ready;
	logic [RES_W-1:0] sample_a;
	logic [RES_W-1:0] sample_b;
	logic             conv_out_a;
	logic             conv_out_a_oe;
	logic             conv_out_b;
	logic             conv_out_b_oe;
	apmfc_mode_type   power_mode;
	apmfc_mode_type   exp_mode;
	logic             analog_pwr;
	logic             ref_pwr;
	logic             analog_ready;
	logic             track_mode;
	int               fail_count;
	int               comparisons;
	logic [23:0]      exp_q [$];

	apmfc_top #(.DEEP_WAKE_CYCLES(DW)) dut (
		.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
		.cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
		.sample_valid(sample_valid), .sample_a(sample_a), .sample_b(sample_b),
		.sample_ready(sample_ready),
		.conv_out_a(conv_out_a), .conv_out_a_oe(conv_out_a_oe),
		.conv_out_b(conv_out_b), .conv_out_b_oe(conv_out_b_oe),
		.power_mode(power_mode), .analog_pwr(analog_pwr), .ref_pwr(ref_pwr),
		.analog_ready(analog_ready), .track_mode(track_mode)
	);

	apmfc_host host (
		.mclk(mclk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
		.probe({track_mode, conv_out_b_oe, conv_out_b, conv_out_a_oe, conv_out_a,
			analog_ready})
	);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic conclude;
		if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude

	function automatic logic exp_bit(input int k, input logic [11:0] own,
			input logic [11:0] oth);
		if (k >= 2 && k <= 13) return own[13-k];
		if (k >= 18 && k <= 29) return oth[29-k];
		return 1'b0;
	endfunction : exp_bit

	// data is only meaningful when the frame starts fully powered
	task automatic run(input int falls, input int hp);
		logic [23:0] w;
		logic        dat;
		w = (exp_q.size() > 0) ? exp_q.pop_front() : 24'h0;
		dat = (exp_mode == APMFC_NORMAL);
		host.frame(falls, hp);
		for (int k = 0; k <= falls; k++) begin
			`CHK("oe_a", k < 32, host.cap[k][2])
			`CHK("oe_b", k < 32, host.cap[k][4])
			if (dat && k < 32) begin
				`CHK("out_a", exp_bit(k, w[23:12], w[11:0]), host.cap[k][1])
				`CHK("out_b", exp_bit(k, w[11:0], w[23:12]), host.cap[k][3])
			end
		end
		`CHK("oe_a idle", 1'b0, conv_out_a_oe)
		`CHK("oe_b idle", 1'b0, conv_out_b_oe)
	endtask : run

	task automatic mode_is(input apmfc_mode_type m, input logic ap, input logic rp);
		`CHK("mode", m, power_mode)
		`CHK("analog_pwr", ap, analog_pwr)
		`CHK("ref_pwr", rp, ref_pwr)
		// later frames judge their data by the mode the rules predict, not the one seen
		exp_mode = m;
	endtask : mode_is

	task automatic t_fill;
		int n;
		n = 0;
		for (int i = 0; i < 10; i++) begin
			sample_a = 12'h9C3 + 12'(i * 291);
			sample_b = 12'h3A5 ^ 12'(i * 517);
			sample_valid = 1'b1;
			if (sample_ready === 1'b1) begin
				exp_q.push_back({sample_a, sample_b});
				n++;
			end
			@(posedge mclk);
			#1;
		end
		sample_valid = 1'b0;
		`CHK("fifo taken", 8, n)
		`CHK("ready full", 1'b0, sample_ready)
	endtask : t_fill

	// reset leaves full power-down, so the first frame is a dummy wake
	task automatic t_wake_full;
		run(32, 20);
		`CHK("rdy early", 1'b0, host.cap[4][0])
		`CHK("rdy late", 1'b1, host.cap[6][0])
		mode_is(APMFC_NORMAL, 1'b1, 1'b1);
		run(32, 20);
		`CHK("hold at fall", 1'b0, host.cap[0][5])
		`CHK("hold at 13", 1'b0, host.cap[13][5])
		`CHK("track at 14", 1'b1, host.cap[14][5])
		`CHK("ready drained", 1'b1, sample_ready)
	endtask : t_wake_full

	task automatic t_normal;
		run(16, 20);
		mode_is(APMFC_NORMAL, 1'b1, 1'b1);
		run(10, 20);
		mode_is(APMFC_NORMAL, 1'b1, 1'b1);
		run(13, 20);
		mode_is(APMFC_NORMAL, 1'b1, 1'b1);
		run(1, 20);
		run(0, 20);
		mode_is(APMFC_NORMAL, 1'b1, 1'b1);
	endtask : t_normal

	task automatic t_power;
		run(2, 20);
		mode_is(APMFC_PARTIAL, 1'b0, 1'b1);
		run(1, 20);
		mode_is(APMFC_PARTIAL, 1'b0, 1'b1);
		run(10, 30);
		mode_is(APMFC_NORMAL, 1'b1, 1'b1);
		`CHK("rdy partial early", 1'b0, host.cap[0][0])
		`CHK("rdy partial late", 1'b1, host.cap[2][0])
		`CHK("hold before edge", 1'b0, host.cap[0][5])
		`CHK("track after edge", 1'b1, host.cap[1][5])
		run(9, 20);
		run(9, 20);
		mode_is(APMFC_FULL, 1'b0, 1'b0);
		run(1, 20);
		mode_is(APMFC_FULL, 1'b0, 1'b0);
		run(12, 20);
		mode_is(APMFC_NORMAL, 1'b1, 1'b1);
		`CHK("rdy deep early", 1'b0, host.cap[4][0])
		`CHK("rdy deep late", 1'b1, host.cap[6][0])
	endtask : t_power

	initial begin
		sys_rst = 1'b1;
		sample_valid = 1'b0;
		sample_a = '0;
		sample_b = '0;
		fail_count = 0;
		comparisons = 0;
		exp_mode = APMFC_FULL;
		repeat (20) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		t_fill;
		t_wake_full;
		t_normal;
		t_power;
		conclude;
	end

	// whole sequence needs about 27 us; a hang is cut well past that
	initial begin
		#200000;
		fail_count++;
		conclude;
	end
endmodule : apmfc_top_tb_top
